// ---- src/dtc_pkg.sv ----
// Constants shared by the dual timer/counter block.
// Assumes a single 50 MHz peripheral clock and an AXI4-Lite host.
package dtc_pkg;
    // ==========================================================
    // Register byte offsets.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_MODE = 8'h04;
    localparam logic [7:0] ADDR_TL0 = 8'h08;
    localparam logic [7:0] ADDR_TH0 = 8'h0c;
    localparam logic [7:0] ADDR_TL1 = 8'h10;
    localparam logic [7:0] ADDR_TH1 = 8'h14;
    // ==========================================================
    // Control register bit positions.
    localparam int CTRL_TR0 = 4;
    localparam int CTRL_TF0 = 5;
    localparam int CTRL_TR1 = 6;
    localparam int CTRL_TF1 = 7;
    // ==========================================================
    // Mode register: one nibble per timer, timer 1 in the upper one.
    localparam int MODE_NIB_W = 4;
    localparam int MODE_SRC = 2;
    localparam int MODE_GATE = 3;
    // ==========================================================
    // Reset values and bus answers.
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================================
    // One peripheral cycle lasts six clock periods.
    localparam int PER_CLKS = 6;
    localparam logic [2:0] PER_LAST = 3'(PER_CLKS - 1);
    // Operating modes in field order 00, 01, 10, 11.
    typedef enum logic [1:0] {MODE_13BIT, MODE_16BIT, MODE_RELOAD, MODE_SPLIT} dtc_mode_t;
endpackage

// ---- src/dtc_timer_top.sv ----
// Two classic byte-wide timer/counters with AXI4-Lite register access.
// Assumes pins synchronous to aclk in timing, but resynchronises them anyway.
//
// Notes on behaviour
// - Run bit set lets the chosen source step the low byte; clear stops it.
// - Cascade: low overflow steps high byte, high overflow sets overflow flag.
// - Setting the run bit leaves both count bytes as they are.
// - Timer source steps once per six-clock peripheral cycle.
// - Counter source samples pin per peripheral cycle; high then low steps.
// - Edge needs two peripheral cycles, so counting tops out at clock/12.
// - Timer 0 uses mode bits 3:0 and control bits 4, 5.
// - Gate clear: run bit alone; gate set: gate pin level also needed.
// - Overflow flag cleared by hardware when its interrupt is vectored.
// - Mode 0: five-bit prescaler in low byte steps high byte, 13 bits.
// - Mode 1: both bytes form one 16-bit counter.
// - Mode 2: low byte overflow sets flag and reloads from high byte.
// - New reload value written to high byte is used at next overflow.
// - Mode 3: timer 0 low byte is a normal 8-bit timer/counter.
// - Mode 3: timer 0 high byte counts clock/6 on timer 1 run, flags timer 1.
// - Timer 1 matches timer 0 in modes 0-2 unless timer 0 is in mode 3 (no run bit, no flag); mode 3 holds its count.
`timescale 1ns/100ps
module dtc_timer_top (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data.
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address.
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data.
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // External pins, index 0 for timer 0.
    input wire logic [1:0] count_pin,
    input wire logic [1:0] external_gate_pin,
    // Interrupt vectoring acknowledge pulses and flags.
    input wire logic [1:0] irq_ack,
    output logic timer0_overflow_flag,
    output logic timer1_overflow_flag
);
    // ==========================================================
    // Bus state.
    logic aw_held_ff, nxt_aw_held, w_held_ff, nxt_w_held;
    logic [7:0] awaddr_ff, nxt_awaddr, wdata_ff, nxt_wdata;
    logic wstrb0_ff, nxt_wstrb0;
    logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
    logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [7:0] rdata_ff, nxt_rdata;
    logic wr_go, wr_hit, rd_hit;
    logic [7:0] rd_val;
    // Timer state.
    logic [7:0] ctrl_ff, nxt_ctrl, mode_ff, nxt_mode;
    logic [7:0] tl0_ff, nxt_tl0, th0_ff, nxt_th0, tl1_ff, nxt_tl1, th1_ff, nxt_th1;
    logic [2:0] div_ff, nxt_div;
    logic tick, set0, set1;
    logic [1:0] cnt_meta_ff, cnt_sync_ff, cnt_smp_ff, nxt_smp;
    logic [1:0] gate_meta_ff, gate_sync_ff, fall, en, inc;
    logic [16:0] s0, s1;
    dtc_pkg::dtc_mode_t m0, m1;

    // ==========================================================
    // One increment of a timer in modes 0 to 2, or of the low byte in mode 3.
    // Result is {overflow, high byte, low byte}.
    function automatic logic [16:0] step(input dtc_pkg::dtc_mode_t m, input logic [7:0] hi,
                                         input logic [7:0] lo);
        logic [5:0] p;
        logic [8:0] l;
        logic [8:0] h;
        p = {1'b0, lo[4:0]} + 6'h01;
        l = {1'b0, lo} + 9'h001;
        h = {1'b0, hi} + 9'h001;
        case (m)
            dtc_pkg::MODE_13BIT: begin
                // Upper three low-byte bits are left alone.
                step = p[5] ? {h, lo[7:5], p[4:0]} : {1'b0, hi, lo[7:5], p[4:0]};
            end
            dtc_pkg::MODE_16BIT: begin
                step = l[8] ? {h, l[7:0]} : {1'b0, hi, l[7:0]};
            end
            dtc_pkg::MODE_RELOAD: begin
                step = l[8] ? {1'b1, hi, hi} : {1'b0, hi, l[7:0]};
            end
            default: begin
                step = {l[8], hi, l[7:0]};
            end
        endcase
    endfunction

    // ==========================================================
    // Peripheral cycle divider: one tick every six clocks.
    assign tick = (div_ff == dtc_pkg::PER_LAST);
    assign nxt_div = tick ? 3'h0 : div_ff + 3'h1;
    assign m0 = dtc_pkg::dtc_mode_t'(mode_ff[1:0]);
    assign m1 = dtc_pkg::dtc_mode_t'(mode_ff[5:4]);

    // Sample the synchronised count pins once per tick.
    always_comb begin
        nxt_smp = tick ? cnt_sync_ff : cnt_smp_ff;
        fall = {2{tick}} & cnt_smp_ff & ~cnt_sync_ff;
    end

    // Only the second flop is ever looked at, so metastability stays contained.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_meta_ff <= 2'h0;
            cnt_sync_ff <= 2'h0;
            gate_meta_ff <= 2'h0;
            gate_sync_ff <= 2'h0;
            cnt_smp_ff <= 2'h0;
            div_ff <= 3'h0;
        end else begin
            cnt_meta_ff <= count_pin;
            cnt_sync_ff <= cnt_meta_ff;
            gate_meta_ff <= external_gate_pin;
            gate_sync_ff <= gate_meta_ff;
            cnt_smp_ff <= nxt_smp;
            div_ff <= nxt_div;
        end
    end

    // ==========================================================
    // Per-timer enable and increment strobe.
    // With timer 0 split, timer 1 loses its run bit and runs unless held in mode 3.
    for (genvar i = 0; i < 2; i++) begin : g_tmr
        localparam int TRB = (i == 0) ? dtc_pkg::CTRL_TR0 : dtc_pkg::CTRL_TR1;
        localparam int NB = i * dtc_pkg::MODE_NIB_W;
        logic run;
        assign run = (i == 1 && m0 == dtc_pkg::MODE_SPLIT) ? 1'b1 : ctrl_ff[TRB];
        assign en[i] = run & (~mode_ff[NB + dtc_pkg::MODE_GATE] | gate_sync_ff[i]);
        assign inc[i] = en[i] & (mode_ff[NB + dtc_pkg::MODE_SRC] ? fall[i] : tick);
    end

    assign s0 = step(m0, th0_ff, tl0_ff);
    assign s1 = step(m1, th1_ff, tl1_ff);
    assign wr_go = aw_held_ff & w_held_ff & ~bvalid_ff;

    // ==========================================================
    // Counter and flag next values; a software write wins over counting.
    // Count bytes are never cleared by the run bit, only by overflow or writes.
    always_comb begin
        nxt_tl0 = tl0_ff;
        nxt_th0 = th0_ff;
        nxt_tl1 = tl1_ff;
        nxt_th1 = th1_ff;
        nxt_ctrl = ctrl_ff;
        nxt_mode = mode_ff;
        set0 = 1'b0;
        set1 = 1'b0;
        if (inc[0]) begin
            nxt_tl0 = s0[7:0];
            set0 = s0[16];
            if (m0 != dtc_pkg::MODE_SPLIT) begin
                nxt_th0 = s0[15:8];
            end
        end
        if (m0 == dtc_pkg::MODE_SPLIT && tick && ctrl_ff[dtc_pkg::CTRL_TR1]) begin
            {set1, nxt_th0} = {1'b0, th0_ff} + 9'h001;
        end
        if (inc[1] && m1 != dtc_pkg::MODE_SPLIT) begin
            {nxt_th1, nxt_tl1} = s1[15:0];
            set1 = set1 | (s1[16] & (m0 != dtc_pkg::MODE_SPLIT));
        end
        if (wr_go && wstrb0_ff) begin
            case (awaddr_ff)
                dtc_pkg::ADDR_CTRL: nxt_ctrl = wdata_ff;
                dtc_pkg::ADDR_MODE: nxt_mode = wdata_ff;
                dtc_pkg::ADDR_TL0: nxt_tl0 = wdata_ff;
                dtc_pkg::ADDR_TH0: nxt_th0 = wdata_ff;
                dtc_pkg::ADDR_TL1: nxt_tl1 = wdata_ff;
                dtc_pkg::ADDR_TH1: nxt_th1 = wdata_ff;
                default: nxt_ctrl = ctrl_ff;
            endcase
        end
        // An overflow in the same cycle as an acknowledge or clear is kept.
        if (!(wr_go && wstrb0_ff && awaddr_ff == dtc_pkg::ADDR_CTRL)) begin
            nxt_ctrl[dtc_pkg::CTRL_TF0] = ctrl_ff[dtc_pkg::CTRL_TF0] & ~irq_ack[0];
            nxt_ctrl[dtc_pkg::CTRL_TF1] = ctrl_ff[dtc_pkg::CTRL_TF1] & ~irq_ack[1];
        end
        nxt_ctrl[dtc_pkg::CTRL_TF0] = nxt_ctrl[dtc_pkg::CTRL_TF0] | set0;
        nxt_ctrl[dtc_pkg::CTRL_TF1] = nxt_ctrl[dtc_pkg::CTRL_TF1] | set1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= dtc_pkg::RST_BYTE;
            mode_ff <= dtc_pkg::RST_BYTE;
            tl0_ff <= dtc_pkg::RST_BYTE;
            th0_ff <= dtc_pkg::RST_BYTE;
            tl1_ff <= dtc_pkg::RST_BYTE;
            th1_ff <= dtc_pkg::RST_BYTE;
        end else begin
            ctrl_ff <= nxt_ctrl;
            mode_ff <= nxt_mode;
            tl0_ff <= nxt_tl0;
            th0_ff <= nxt_th0;
            tl1_ff <= nxt_tl1;
            th1_ff <= nxt_th1;
        end
    end

    assign timer0_overflow_flag = ctrl_ff[dtc_pkg::CTRL_TF0];
    assign timer1_overflow_flag = ctrl_ff[dtc_pkg::CTRL_TF1];

    // ==========================================================
    // AXI4-Lite slave: address and data latch independently, write on both.
    always_comb begin
        wr_hit = (awaddr_ff <= dtc_pkg::ADDR_TH1) && (awaddr_ff[1:0] == 2'h0);
        rd_hit = (s_axi_araddr <= dtc_pkg::ADDR_TH1) && (s_axi_araddr[1:0] == 2'h0);
        case (s_axi_araddr)
            dtc_pkg::ADDR_CTRL: rd_val = ctrl_ff;
            dtc_pkg::ADDR_MODE: rd_val = mode_ff;
            dtc_pkg::ADDR_TL0: rd_val = tl0_ff;
            dtc_pkg::ADDR_TH0: rd_val = th0_ff;
            dtc_pkg::ADDR_TL1: rd_val = tl1_ff;
            dtc_pkg::ADDR_TH1: rd_val = th1_ff;
            default: rd_val = dtc_pkg::RST_BYTE;
        endcase
        nxt_aw_held = (aw_held_ff & ~wr_go) | (s_axi_awvalid & s_axi_awready);
        nxt_awaddr = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : awaddr_ff;
        nxt_w_held = (w_held_ff & ~wr_go) | (s_axi_wvalid & s_axi_wready);
        nxt_wdata = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata[7:0] : wdata_ff;
        nxt_wstrb0 = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb[0] : wstrb0_ff;
        nxt_bvalid = wr_go | (bvalid_ff & ~s_axi_bready);
        nxt_bresp = wr_go ? (wr_hit ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR) : bresp_ff;
        nxt_rvalid = (s_axi_arvalid & s_axi_arready) | (rvalid_ff & ~s_axi_rready);
        nxt_rdata = (s_axi_arvalid & s_axi_arready) ? rd_val : rdata_ff;
        nxt_rresp = (s_axi_arvalid & s_axi_arready) ?
                    (rd_hit ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR) : rresp_ff;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awaddr_ff <= dtc_pkg::RST_BYTE;
            wdata_ff <= dtc_pkg::RST_BYTE;
            wstrb0_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= dtc_pkg::RESP_OKAY;
            rvalid_ff <= 1'b0;
            rdata_ff <= dtc_pkg::RST_BYTE;
            rresp_ff <= dtc_pkg::RESP_OKAY;
        end else begin
            aw_held_ff <= nxt_aw_held;
            w_held_ff <= nxt_w_held;
            awaddr_ff <= nxt_awaddr;
            wdata_ff <= nxt_wdata;
            wstrb0_ff <= nxt_wstrb0;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end

    // Readies are combinational; one write and one read are in flight at most.
    assign s_axi_awready = ~aw_held_ff & ~bvalid_ff;
    assign s_axi_wready = ~w_held_ff & ~bvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = ~rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = {24'h000000, rdata_ff};
    assign s_axi_rresp = rresp_ff;

    // ==========================================================
    // Checks on the counting behaviour.
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_tick;
        tick |=> !tick [*5] ##1 tick;
    endproperty
    a_tick: assert property (p_tick) else $error("Peripheral tick spacing wrong.");
    property p_stop;
        (!en[0] && !wr_go && m0 != dtc_pkg::MODE_SPLIT) |=> tl0_ff == $past(tl0_ff);
    endproperty
    a_stop: assert property (p_stop) else $error("Timer 0 moved while stopped.");
    // In split mode the high byte runs on the other run bit, so only whole-timer modes apply.
    property p_run_keep;
        (wr_go && awaddr_ff == dtc_pkg::ADDR_CTRL && !ctrl_ff[dtc_pkg::CTRL_TR0] && !inc[0]
            && m0 != dtc_pkg::MODE_SPLIT) |=> $stable(tl0_ff) && $stable(th0_ff);
    endproperty
    a_run_keep: assert property (p_run_keep) else $error("Run bit changed counts.");
    property p_fall;
        inc[0] && mode_ff[dtc_pkg::MODE_SRC] |-> cnt_smp_ff[0] && !cnt_sync_ff[0] && tick;
    endproperty
    a_fall: assert property (p_fall) else $error("Counter stepped without falling edge.");
    property p_gate;
        (mode_ff[dtc_pkg::MODE_GATE] && !gate_sync_ff[0]) |-> !en[0];
    endproperty
    a_gate: assert property (p_gate) else $error("Gate pin ignored.");
    property p_ack;
        (irq_ack[0] && !set0 && !wr_go) |=> !timer0_overflow_flag;
    endproperty
    a_ack: assert property (p_ack) else $error("Flag not cleared on vectoring.");
    property p_m0;
        (m0 == dtc_pkg::MODE_13BIT && inc[0] && tl0_ff[4:0] == 5'h1f && !wr_go)
            |=> th0_ff == $past(th0_ff) + 8'h01 && tl0_ff[4:0] == 5'h00;
    endproperty
    a_m0: assert property (p_m0) else $error("Prescaler carry lost.");
    property p_reload;
        (m0 == dtc_pkg::MODE_RELOAD && inc[0] && tl0_ff == 8'hff && !wr_go)
            |=> tl0_ff == $past(th0_ff) && timer0_overflow_flag;
    endproperty
    a_reload: assert property (p_reload) else $error("Reload failed.");
    property p_split_hi;
        (m0 == dtc_pkg::MODE_SPLIT && tick && ctrl_ff[dtc_pkg::CTRL_TR1] && th0_ff == 8'hff && !wr_go)
            |=> th0_ff == 8'h00 && timer1_overflow_flag;
    endproperty
    a_split_hi: assert property (p_split_hi) else $error("Split high byte wrong.");
    property p_hold1;
        (m1 == dtc_pkg::MODE_SPLIT && !wr_go) |=> $stable(tl1_ff) && $stable(th1_ff);
    endproperty
    a_hold1: assert property (p_hold1) else $error("Timer 1 moved in hold.");
endmodule

// ---- verif/dtc_pin_model.sv ----
// Model of the far side: the external count pins and the gate pins.
// Assumes the bench sets run, half period and gate levels just after a clock edge.
`timescale 1ns/100ps
module dtc_pin_model (
    // Clock.
    input wire logic aclk,
    // Control from the bench.
    input wire logic run,
    input wire logic [7:0] half,
    input wire logic [1:0] gate_level,
    // Pins toward the block.
    output logic [1:0] count_pin,
    output logic [1:0] external_gate_pin
);
    // ==========================================================
    // Square wave source.
    logic [7:0] hold_cnt;
    // Each level stands for half clocks; a half of six is one full peripheral cycle, the fastest legal rate.
    always @(posedge aclk) begin
        if (!run) begin
            count_pin <= 2'b11;
            hold_cnt <= 8'h00;
        end else if (8'(hold_cnt + 8'h01) >= half) begin
            count_pin <= ~count_pin;
            hold_cnt <= 8'h00;
        end else begin
            hold_cnt <= 8'(hold_cnt + 8'h01);
        end
    end
    // Gate levels come straight from the bench.
    assign external_gate_pin = gate_level;
endmodule

// ---- verif/tb.sv ----
// Self-checking bench for the dual timer block, one task per scenario.
// Assumes the pin model on the far side and a 50 MHz clock.
`timescale 1ns/100ps
module tb;
    // ==========================================================
    // Signals and counters.
    localparam logic [1:0] OK = dtc_pkg::RESP_OKAY;
    localparam logic [7:0] CTL = dtc_pkg::ADDR_CTRL;
    localparam logic [7:0] MOD = dtc_pkg::ADDR_MODE;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, prun;
    logic awready, wready, bvalid, arready, rvalid, f0, f1;
    logic [7:0] awaddr, araddr, phalf;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp, irq_ack, cpin, gpin, glev;
    int bad_count, samples_checked, cyc;
    // The design and the far side.
    dtc_timer_top u_dtc_timer_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .count_pin(cpin), .external_gate_pin(gpin), .irq_ack(irq_ack),
        .timer0_overflow_flag(f0), .timer1_overflow_flag(f1));
    dtc_pin_model u_dtc_pin_model (.aclk(aclk), .run(prun), .half(phalf), .gate_level(glev),
        .count_pin(cpin), .external_gate_pin(gpin));
    // ==========================================================
    // Clock and a free cycle count for measuring periods.
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    always @(posedge aclk) cyc <= cyc + 1;
    // ==========================================================
    // Shared helpers.
    function automatic logic flag(int i);
        return i ? f1 : f0;
    endfunction
    function automatic logic [7:0] lo_a(int i);
        return i ? dtc_pkg::ADDR_TL1 : dtc_pkg::ADDR_TL0;
    endfunction
    function automatic logic [7:0] hi_a(int i);
        return i ? dtc_pkg::ADDR_TH1 : dtc_pkg::ADDR_TH0;
    endfunction
    function automatic logic [7:0] run_b(int i);
        return 8'h01 << (i ? dtc_pkg::CTRL_TR1 : dtc_pkg::CTRL_TR0);
    endfunction
    task automatic stop_test();
        $display("compares %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic hang(string what);
        bad_count++;
        $display("ERROR %s wait ran out", what);
        stop_test();
    endtask
    // Bus write: address and data offered together, each dropped when taken.
    // One idle edge closes each transfer, so a following call never re-raises a strobe in the same step.
    task automatic wr(logic [7:0] a, logic [7:0] d, logic [1:0] er = OK);
        int n;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            n++;
            if (n > 40) hang("write");
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        check("bresp", 32'(bresp), 32'(er));
        @(posedge aclk);
    endtask
    // Bus read with the answer taken at the edge that shows rvalid.
    task automatic rd(logic [7:0] a, logic [7:0] ed, string name, logic [1:0] er = OK);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            n++;
            if (n > 40) hang("read");
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        check(name, rdata, {24'h0, ed});
        check("rresp", 32'(rresp), 32'(er));
        @(posedge aclk);
    endtask
    task automatic wait_flag(int i, int bound, output int at);
        int n;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (n > bound) hang("flag");
        end while (flag(i) !== 1'b1);
        at = cyc;
    endtask
    // Vectoring acknowledge pulse, then the flag must be down.
    task automatic ack(int i);
        irq_ack[i] <= 1'b1;
        @(posedge aclk);
        irq_ack[i] <= 1'b0;
        @(posedge aclk);
        check("flag after ack", 32'(flag(i)), 32'h0);
    endtask
    // ==========================================================
    // Scenarios.
    task automatic t_reset();
        for (int a = 0; a <= 24; a += 4) begin
            rd(8'(a), dtc_pkg::RST_BYTE, "reset value", (a == 24) ? dtc_pkg::RESP_SLVERR : OK);
        end
        wr(8'h18, 8'h5a, dtc_pkg::RESP_SLVERR);
        wr(hi_a(1), 8'ha5);
        rd(hi_a(1), 8'ha5, "preset readback");
    endtask
    // Modes 0 and 1 overflow from a preset; high byte must end at zero, low byte at zero in mode 1 and e0 in mode 0.
    task automatic t_cascade(int i, logic [1:0] m, int bound);
        int at;
        wr(MOD, 8'(m) << (4 * i));
        wr(lo_a(i), 8'hfe);
        wr(hi_a(i), 8'hfe);
        wr(CTL, run_b(i));
        rd(CTL, run_b(i), "control run");
        wait_flag(i, bound, at);
        wr(CTL, 8'h00);
        rd(hi_a(i), 8'h00, "high byte");
        rd(lo_a(i), (m == 2'b00) ? 8'he0 : 8'h00, "low byte");
    endtask
    task automatic t_reload();
        int t1, t2, t3;
        wr(MOD, 8'h02);
        wr(lo_a(0), 8'hfc);
        wr(hi_a(0), 8'hfc);
        wr(CTL, run_b(0));
        wait_flag(0, 60, t1);
        rd(CTL, 8'h30, "control flag");
        ack(0);
        wr(hi_a(0), 8'hf8);
        wait_flag(0, 60, t2);
        ack(0);
        wait_flag(0, 90, t3);
        ack(0);
        check("reload period", 32'(t2 - t1), 32'(4 * dtc_pkg::PER_CLKS));
        check("new reload period", 32'(t3 - t2), 32'(8 * dtc_pkg::PER_CLKS));
        rd(hi_a(0), 8'hf8, "reload byte kept");
        wr(CTL, 8'h00);
    endtask
    // Gate bit set: the gate pin level must hold counting off.
    task automatic t_gate();
        int at;
        wr(MOD, 8'h0a);
        wr(lo_a(0), 8'hfc);
        wr(CTL, run_b(0));
        repeat (60) @(posedge aclk);
        check("gated flag", 32'(f0), 32'h0);
        rd(lo_a(0), 8'hfc, "gated low byte");
        glev <= 2'b01;
        wait_flag(0, 60, at);
        wr(CTL, 8'h00);
    endtask
    // Falling edges at the fastest legal rate, then at a slower one.
    task automatic t_pins();
        int t1, t2, t3, t4;
        wr(MOD, 8'h06);
        wr(lo_a(0), 8'hfc);
        wr(hi_a(0), 8'hfc);
        phalf <= 8'h06;
        prun <= 1'b1;
        wr(CTL, run_b(0));
        wait_flag(0, 200, t1);
        ack(0);
        wait_flag(0, 200, t2);
        phalf <= 8'h09;
        ack(0);
        wait_flag(0, 200, t3);
        ack(0);
        wait_flag(0, 200, t4);
        check("pin period fast", 32'(t2 - t1), 32'h30);
        check("pin period slow", 32'(t4 - t3), 32'h48);
        wr(CTL, 8'h00);
        prun <= 1'b0;
    endtask
    // Timer 0 split, timer 1 held.
    task automatic t_split();
        int at;
        wr(MOD, 8'h33);
        wr(lo_a(0), 8'hfe);
        wr(hi_a(0), 8'hfc);
        wr(lo_a(1), 8'h5a);
        wr(hi_a(1), 8'h3c);
        wr(CTL, run_b(1));
        wait_flag(1, 60, at);
        check("low split idle", 32'(f0), 32'h0);
        rd(lo_a(0), 8'hfe, "split low byte");
        rd(lo_a(1), 8'h5a, "held low byte");
        rd(hi_a(1), 8'h3c, "held high byte");
        wr(CTL, run_b(0) | run_b(1));
        wait_flag(0, 60, at);
        wr(CTL, 8'h00);
    endtask
    // ==========================================================
    // Main sequence.
    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, prun} = 6'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        irq_ack = 2'b00;
        glev = 2'b00;
        phalf = 8'h06;
        {bad_count, samples_checked} = '0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        for (int i = 0; i < 2; i++) begin
            t_cascade(i, 2'b00, 300);
            t_cascade(i, 2'b01, 1700);
        end
        t_reload();
        t_gate();
        t_pins();
        t_split();
        stop_test();
    end
endmodule
